// >>> common/pd_map.svh
`ifndef PD_MAP_SVH
`define PD_MAP_SVH
`define OP_DEEP_OR_ULTRA 8'hb9
`define OP_ULTRA_ONLY 8'h79
`define OP_RESUME 8'hab
`define OP_RST_ENABLE 8'h66
`define OP_RST_DEVICE 8'h99
`define OP_TERMINATE 8'hf0
`define OP_PROG_0 8'h02
`define OP_PROG_1 8'haf
`define OP_PROG_2 8'had
`define OP_PROG_3 8'ha2
`define OP_PROG_4 8'h32
`define OP_PROG_5 8'h0a
`define OP_PROG_6 8'h88
`define OP_PROG_7 8'h9b
`define OP_ERASE_0 8'h81
`define OP_ERASE_1 8'hdb
`define OP_ERASE_2 8'h20
`define OP_ERASE_3 8'h52
`define OP_ERASE_4 8'hd8
`define OP_ERASE_5 8'h60
`define OP_ERASE_6 8'hc7
`define PD_SELECT_BIT 7
`define RST_PIN_EN_BIT 7
`define OPCODE_BITS 8
`define RESET_SEQ_CYCLES 8'h08
`endif

// >>> common/pd_pkg.sv
package pd_pkg;
  // power state of the flash core
  typedef enum logic [2:0] {
    st_idle,
    st_busy,
    st_deep,
    st_ultra,
    st_reset_seq
  } pd_state_e;
  typedef enum logic [1:0] {
    op_none,
    op_program,
    op_erase
  } op_class_e;
endpackage

// >>> rtl/opcode_shifter.sv
`timescale 1ns/1ps
`include "pd_map.svh"
// =====================================================================
// serial opcode capture on the spi link
// sclk and cs arrive raw; both pass two flops before any use
module opcode_shifter (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic [7:0] opcode_q,
  output logic opcode_valid_q,
  output logic cs_rise_q
);
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] mosi_s_q;
  logic sclk_old_q;
  logic cs_old_q;
  logic [7:0] shift_q;
  logic [3:0] count_q;
  logic done_q;
  wire sclk_rise = sclk_s_q[1] & ~sclk_old_q;
  wire cs_active = ~cs_s_q[1];
  wire [7:0] shift_d = {shift_q[6:0], mosi_s_q[1]};
  wire last_bit = (count_q == 4'(`OPCODE_BITS - 1));
  // two-flop synchronisers, then edge memories
  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sclk_old_q <= 1'h0;
      cs_old_q <= 1'h1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk};
      cs_s_q <= {cs_s_q[0], cs_n};
      mosi_s_q <= {mosi_s_q[0], mosi};
      sclk_old_q <= sclk_s_q[1];
      cs_old_q <= cs_s_q[1];
    end
  end
  // first byte of each frame is the opcode; later bytes are ignored
  always_ff @(posedge clock) begin
    if (reset || !cs_active) begin
      shift_q <= 8'h00;
      count_q <= 4'h0;
      done_q <= 1'h0;
    end else if (sclk_rise && !done_q) begin
      shift_q <= shift_d;
      count_q <= count_q + 4'h1;
      done_q <= last_bit;
    end
  end
  // opcode pulse on the eighth rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      opcode_q <= 8'h00;
      opcode_valid_q <= 1'h0;
      cs_rise_q <= 1'h0;
    end else begin
      opcode_valid_q <= cs_active && sclk_rise && !done_q && last_bit;
      if (cs_active && sclk_rise && !done_q && last_bit) begin
        opcode_q <= shift_d;
      end
      cs_rise_q <= cs_s_q[1] & ~cs_old_q;
    end
  end
endmodule // opcode_shifter

// >>> rtl/flash_power_down_control.sv
`timescale 1ns/1ps
`include "pd_map.svh"
module flash_power_down_control
  import pd_pkg::*;
#(
  parameter int RESET_CYCLES = `RESET_SEQ_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] status_reg_four,
  input wire logic [7:0] status_reg_three,
  input wire logic reset_pin_n,
  input wire logic jedec_reset,
  input wire logic op_done,
  input wire logic program_error_in,
  input wire logic erase_error_in,
  output logic deep_sleep_state,
  output logic ultra_deep_sleep_state,
  output logic sram_valid,
  output logic busy,
  output logic op_abort,
  output logic device_reset,
  output logic program_error_flag,
  output logic erase_error_flag,
  output logic output_enable
);
  pd_state_e state_q, state_d;
  op_class_e class_q;
  logic [7:0] opcode;
  logic opcode_valid;
  logic cs_rise;
  logic rst_armed_q;
  logic [7:0] seq_q;
  logic [1:0] pin_s_q;
  logic [1:0] jedec_s_q;
  logic sram_q;
  logic pe_q, ee_q, abort_q, devrst_q;

  // ===================================================================
  // serial front end
  opcode_shifter u_shift (
    .clock(clock),
    .reset(reset),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .opcode_q(opcode),
    .opcode_valid_q(opcode_valid),
    .cs_rise_q(cs_rise)
  );

  // ===================================================================
  // opcode classification
  function automatic op_class_e classify(input logic [7:0] op);
    if (op == `OP_PROG_0 || op == `OP_PROG_1 || op == `OP_PROG_2 ||
        op == `OP_PROG_3 || op == `OP_PROG_4 || op == `OP_PROG_5 ||
        op == `OP_PROG_6 || op == `OP_PROG_7)
      return op_program;
    else if (op == `OP_ERASE_0 || op == `OP_ERASE_1 ||
             op == `OP_ERASE_2 || op == `OP_ERASE_3 ||
             op == `OP_ERASE_4 || op == `OP_ERASE_5 ||
             op == `OP_ERASE_6)
      return op_erase;
    else
      return op_none;
  endfunction

  // pin reset only counts when enabled in status_reg_three
  wire pin_reset = ~pin_s_q[1] & status_reg_three[`RST_PIN_EN_BIT];
  wire hard_reset = pin_reset | jedec_s_q[1];
  wire sel_deep = status_reg_four[`PD_SELECT_BIT];
  wire got = opcode_valid;
  wire is_b9 = got && opcode == `OP_DEEP_OR_ULTRA;
  wire is_79 = got && opcode == `OP_ULTRA_ONLY;
  wire is_ab = got && opcode == `OP_RESUME;
  wire is_f0 = got && opcode == `OP_TERMINATE;
  wire is_66 = got && opcode == `OP_RST_ENABLE;
  wire is_99 = got && opcode == `OP_RST_DEVICE;
  wire soft_reset = is_99 && rst_armed_q;
  wire op_class = got && classify(opcode) != op_none;
  wire seq_end = (seq_q == 8'h01);
  // soft reset while idle or busy resets the device; not in sleep
  wire awake = state_q == st_idle || state_q == st_busy;
  wire full_reset = hard_reset || (soft_reset && awake);

  // ===================================================================
  // synchronisers for the reset pin and jedec request
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s_q <= 2'h3;
      jedec_s_q <= 2'h0;
    end else begin
      pin_s_q <= {pin_s_q[0], reset_pin_n};
      jedec_s_q <= {jedec_s_q[0], jedec_reset};
    end
  end

  // ===================================================================
  // next state; cs_rise deliberately unused for wake
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (is_b9 && sel_deep) begin
          state_d = st_deep;
        end else if (is_b9 || is_79) begin
          state_d = st_ultra;
        end else if (op_class) begin
          state_d = st_busy;
        end
      end
      st_busy: begin
        if (is_f0 || op_done) begin
          state_d = st_idle;
        end
      end
      st_deep: begin
        if (is_ab || soft_reset) begin
          state_d = st_idle;
        end
      end
      st_ultra: begin
        // f0 and 66/99 stay asleep
        if (is_ab) begin
          state_d = st_reset_seq;
        end
      end
      st_reset_seq: begin
        if (seq_end) begin
          state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
    if (full_reset) begin
      state_d = st_reset_seq;
    end
  end

  // ===================================================================
  // state, reset arming and reset sequence counter
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= st_reset_seq;
      rst_armed_q <= 1'h0;
      seq_q <= 8'(RESET_CYCLES);
      class_q <= op_none;
    end else begin
      state_q <= state_d;
      if (got) begin
        rst_armed_q <= is_66;
      end
      // a held reset keeps reloading, so the count restarts on release
      if (state_d == st_reset_seq &&
          (state_q != st_reset_seq || full_reset)) begin
        seq_q <= 8'(RESET_CYCLES);
      end else if (seq_q != 8'h00) begin
        seq_q <= seq_q - 8'h01;
      end
      if (state_q == st_idle && op_class) begin
        class_q <= classify(opcode);
      end
    end
  end

  // ===================================================================
  // buffer validity, error flags, pulses; reset clear beats error set
  always_ff @(posedge clock) begin
    if (reset) begin
      sram_q <= 1'h0;
      pe_q <= 1'h0;
      ee_q <= 1'h0;
      abort_q <= 1'h0;
      devrst_q <= 1'h0;
    end else begin
      abort_q <= state_q == st_busy && (full_reset || is_f0);
      devrst_q <= state_d == st_reset_seq && state_q != st_reset_seq;
      if (state_d == st_reset_seq) begin
        sram_q <= 1'h0;
      end else if (state_d == st_ultra) begin
        sram_q <= 1'h0;
      end else if (state_q == st_reset_seq && seq_end) begin
        sram_q <= 1'h1;
      end
      // deep wake and soft reset in deep sleep leave flags; a pass through the reset sequence clears them
      if (state_q == st_reset_seq) begin
        pe_q <= 1'h0;
        ee_q <= 1'h0;
      end else if (state_q == st_busy) begin
        pe_q <= pe_q | (class_q == op_program &&
                        (program_error_in || is_f0));
        ee_q <= ee_q | (class_q == op_erase && (erase_error_in || is_f0));
      end else if (state_q == st_idle && op_class) begin
        pe_q <= classify(opcode) == op_program ? 1'h0 : pe_q;
        ee_q <= classify(opcode) == op_erase ? 1'h0 : ee_q;
      end
    end
  end

  // ===================================================================
  // registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      deep_sleep_state <= 1'h0;
      ultra_deep_sleep_state <= 1'h0;
      busy <= 1'h1;
      output_enable <= 1'h0;
    end else begin
      deep_sleep_state <= state_d == st_deep;
      ultra_deep_sleep_state <= state_d == st_ultra;
      busy <= state_d == st_busy || state_d == st_reset_seq;
      // no read data path in this block, so the driver never turns on
      output_enable <= 1'h0;
    end
  end
  assign sram_valid = sram_q;
  assign program_error_flag = pe_q;
  assign erase_error_flag = ee_q;
  assign op_abort = abort_q;
  assign device_reset = devrst_q;

  // ===================================================================
  // checks
  sequence deep_entry_s;
    state_q == st_idle && is_b9 && sel_deep && !full_reset;
  endsequence
  // reset sequence entered, then buffer and error flags cleared
  sequence reset_run_s;
    state_q == st_reset_seq ##1 !sram_q && !pe_q && !ee_q;
  endsequence
  deep_entry_a: assert property (@(posedge clock) disable iff (reset)
    deep_entry_s |=> state_q == st_deep)
    else $error("b9 with select set missed deep sleep");
  ultra_entry_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_idle && (is_79 || (is_b9 && !sel_deep)) && !full_reset
    |=> state_q == st_ultra && !sram_q)
    else $error("ultra entry wrong");
  deep_resume_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_deep && is_ab && !full_reset
    |=> state_q == st_idle && $stable(pe_q))
    else $error("ab from deep did not reach idle");
  ultra_resume_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_ultra && is_ab |=> reset_run_s)
    else $error("ab from ultra did not reset");
  soft_wake_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_deep && soft_reset && !hard_reset
    |=> state_q == st_idle && sram_q && !device_reset)
    else $error("soft reset in deep sleep handled wrong");
  ultra_hold_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_ultra && !is_ab && !hard_reset
    |=> state_q == st_ultra)
    else $error("ultra sleep left without wake");
  cs_no_wake_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_deep && cs_rise && !got && !hard_reset
    |=> state_q == st_deep)
    else $error("cs release woke the device");
  hard_wake_a: assert property (@(posedge clock) disable iff (reset)
    hard_reset |=> reset_run_s)
    else $error("hard reset ignored");
  reset_abort_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_busy && full_reset |=> op_abort && device_reset)
    else $error("reset during busy op not aborted");
  term_halt_a: assert property (@(posedge clock) disable iff (reset)
    state_q == st_busy && is_f0 && !full_reset
    |=> state_q == st_idle && op_abort && !device_reset)
    else $error("terminate handled wrong");
endmodule // flash_power_down_control

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
// ======
// spi host sending one opcode per frame
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // link clock stands low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // msb first, mode 0; n of 0 toggles select and flips mosi, with no clock
  task automatic frame(input logic [15:0] b, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = b[15-i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    mosi = ~mosi; // released line must not keep stale data
    #400;
  endtask
endmodule // spi_host_model

// >>> sim/tb.sv
`timescale 1ns/1ps
// ======
// bench for the sleep-state controller
module tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sclk, cs_n, mosi;
  logic [7:0] sr4 = 8'h00;
  logic [7:0] sr3 = 8'h00;
  logic pin_n = 1'b1, jedec = 1'b0, done = 1'b0, perr = 1'b0, eerr = 1'b0;
  logic deep, ultra, sram_v, busy, abort, dev_rst, pflag, eflag, oe;
  int num_errors = 0, checks = 0, st = 0, sram = 1, pe = 0, armed = 0;
  int exp_rst = 0, exp_abort = 0, n_rst = 0, n_abort = 0;
  int ee = 0, cls = 0;
  logic [31:0] seed = 32'h60af;
  // program then erase opcodes
  logic [7:0] ops [15] = '{8'h02, 8'haf, 8'had, 8'ha2, 8'h32, 8'h0a,
    8'h88, 8'h9b, 8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};

  always #12.5 clock = ~clock;

  spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  flash_power_down_control #(.RESET_CYCLES(8)) u_dut (
    .clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .status_reg_four(sr4), .status_reg_three(sr3), .reset_pin_n(pin_n),
    .jedec_reset(jedec), .op_done(done), .program_error_in(perr),
    .erase_error_in(eerr), .deep_sleep_state(deep),
    .ultra_deep_sleep_state(ultra), .sram_valid(sram_v), .busy(busy),
    .op_abort(abort), .device_reset(dev_rst), .program_error_flag(pflag),
    .erase_error_flag(eflag), .output_enable(oe));

  // pulses are counted so a missed or extra one shows
  always @(posedge clock) begin
    if (dev_rst === 1'b1) n_rst++;
    if (abort === 1'b1) n_abort++;
  end

  // ======
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  // bounded wait; a hang ends the run
  task automatic wait_busy(input logic b);
    int n;
    n = 0;
    while (busy !== b) begin
      tick(1);
      n++;
      if (n > 400) begin
        num_errors++;
        conclude();
      end
    end
  endtask

  // behavioural model of the sleep states
  function automatic void model(input logic [7:0] op);
    if (st >= 2) begin
      if (op == 8'hab) begin
        if (st == 3) begin
          exp_rst++;
          pe = 0;
          ee = 0;
          sram = -1;
        end
        st = 0;
      end else if (op == 8'h99 && armed && st == 2) begin
        st = 0;
      end
    end else if (st == 1) begin
      if (op == 8'hf0 || (op == 8'h99 && armed)) begin
        exp_abort++;
        exp_rst += (op == 8'h99);
        st = 0;
        if (op == 8'h99) begin
          pe = 0;
          ee = 0;
        end else if (cls == 1) begin
          pe = 1;
        end else begin
          ee = 1;
        end
      end
    end else if (op == 8'hb9 || op == 8'h79) begin
      st = (op == 8'hb9 && sr4[7]) ? 2 : 3;
      if (st == 3) sram = 0;
    end else begin
      for (int i = 0; i < 15; i++) begin
        if (op == ops[i]) begin
          st = 1;
          cls = (i < 8) ? 1 : 2;
          if (i < 8) pe = 0;
          else ee = 0;
        end
      end
    end
    armed = (op == 8'h66);
  endfunction

  // let the opcode land, then compare all outputs, sram_valid only while the model knows it
  task automatic settle();
    tick(12);
    wait_busy(st == 1);
    check("deep", deep, st == 2);
    check("ultra", ultra, st == 3);
    check("busy", busy, st == 1);
    check("out_en", oe, 1'b0);
    check("resets", n_rst == exp_rst, 1'b1);
    check("aborts", n_abort == exp_abort, 1'b1);
    check("perr_flag", pflag, pe[0]);
    check("eerr_flag", eflag, ee[0]);
    if (sram >= 0) check("sram", sram_v, sram[0]);
  endtask

  // random tail byte is ignored by the device
  task automatic cmd(input logic [7:0] op);
    seed = lfsr(seed);
    u_host.frame({op, seed[7:0]}, 16);
    model(op);
    settle();
  endtask

  task automatic sel(input logic b);
    seed = lfsr(seed);
    sr4 = {b, seed[6:0]};
  endtask

  task automatic por();
    reset = 1'b1;
    tick(8);
    reset = 1'b0;
    tick(2);
    wait_busy(1'b0);
    st = 0;
    sram = 1;
    pe = 0;
    ee = 0;
    armed = 0;
    exp_rst = n_rst;
    exp_abort = n_abort;
  endtask

  // ======
  // main sequence
  initial begin
    por();
    sel(1'b1);
    cmd(8'hb9);
    cmd(8'hf0);
    u_host.frame(16'h0000, 0);
    settle();
    u_host.frame(16'hab00, 4);
    settle();
    cmd(8'h02);
    cmd(8'hab);
    cmd(8'hb9);
    cmd(8'h66);
    cmd(8'hf0);
    cmd(8'h99);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'h02);
    perr = 1'b1;
    tick(1);
    perr = 1'b0;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    st = 0;
    pe = 1;
    settle();
    cmd(8'hb9);
    cmd(8'hab);
    check("perr", pflag, pe[0]);
    sel(1'b0);
    cmd(8'hb9);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'hab);
    check("perr", pflag, pe[0]);
    check("eerr", eflag, 1'b0);
    sel(1'b1);
    cmd(8'h79);
    cmd(8'h66);
    cmd(8'h99);
    jedec = 1'b1;
    tick(4);
    jedec = 1'b0;
    st = 0;
    sram = -1;
    pe = 0;
    ee = 0;
    exp_rst++;
    settle();
    for (int i = 0; i < 15; i++) begin
      cmd(ops[i]);
      eerr = (i >= 8);
      tick(1);
      eerr = 1'b0;
      check("eerr_set", eflag, i >= 8);
      cmd(8'hf0);
    end
    seed = lfsr(seed);
    sr3 = {1'b1, seed[6:0]};
    cmd(8'hd8);
    pin_n = 1'b0;
    tick(4);
    pin_n = 1'b1;
    st = 0;
    pe = 0;
    ee = 0;
    exp_rst++;
    exp_abort++;
    settle();
    cmd(8'h20);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'hb9);
    por();
    settle();
    conclude();
  end
endmodule // tb
